// >>> include/mfd_regs.svh
// Constants for the instruction format decoder: opcode patterns,
// field positions and timing counts.
// Assumes 16-bit program words and a 10 MHz core oscillator.
`ifndef MFD_REGS_SVH
`define MFD_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define MFD_CLK_PERIOD_NS    100
`define MFD_OSC_PER_CYCLE    4
`define MFD_PHASE_W          2
`define MFD_PHASE_LAST       2'h3

// ****************************************************************
// Word layout
// ****************************************************************
`define MFD_WORD_W           16
`define MFD_WORD2_TAG        4'hf
`define MFD_NOP_WORD         16'hf000
`define MFD_FILE_LSB         0
`define MFD_FILE_W           8
`define MFD_DEST_BIT         9
`define MFD_ACCESS_BIT       8
`define MFD_BITNUM_LSB       9
`define MFD_DADDR_W          12
`define MFD_BRANCH_W         20

// ****************************************************************
// Two-word first words
// ****************************************************************
`define MFD_OP_MOVE2         4'hc
`define MFD_OP_CALL          7'h76
`define MFD_OP_GOTO          8'hef
`define MFD_OP_PTRLOAD       10'h3b8

// ****************************************************************
// Data addresses
// ****************************************************************
`define MFD_ACCESS_SPLIT     8'h80
`define MFD_ACCESS_HI_BANK   4'hf
`define MFD_ACCESS_LO_BANK   4'h0
`define MFD_PORT_ADDR_LO     12'hf80
`define MFD_PORT_ADDR_HI     12'hf84
`define MFD_TIMER0_ADDR      12'hfd6

`endif

// >>> include/mfd_pkg.sv
// Types shared by the instruction format decoder.
// Assumes mfd_regs.svh supplies the numeric constants.
package mfd_pkg;

    typedef enum logic [1:0] {
        MFD_CLS_BYTE,
        MFD_CLS_BIT,
        MFD_CLS_LIT,
        MFD_CLS_CTRL
    } mfd_class_e;

    typedef enum logic [1:0] {
        MFD_SEQ_RUN,
        MFD_SEQ_WORD2,
        MFD_SEQ_FLUSH
    } mfd_seq_e;

endpackage

// >>> design/mfd_phase_div.sv
// Divide-by-four phase counter for the instruction cycle.
// Assumes one core oscillator clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "mfd_regs.svh"

module mfd_phase_div import mfd_pkg::*; (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    output logic [`MFD_PHASE_W-1:0]        phase_o,
    output logic                           cycle_end_o
);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            phase_o <= '0;
        end else begin
            phase_o <= phase_o + 2'h1;
        end
    end

    // Pulse in the last phase of each instruction cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cycle_end_o <= 1'b0;
        end else begin
            cycle_end_o <= (phase_o == (`MFD_PHASE_LAST - 2'h1));
        end
    end

endmodule

// >>> design/mfd_decode.sv
// Instruction format decoder and cycle sequencer of an 8-bit core.
// Assumes program memory presents the next word steady at cycle end.
//
// Contract
// - A single-word instruction is one 16-bit word: opcode plus operands.
// - Exactly four instructions span two consecutive words, 32 bits.
// - A second word carries all ones in its top four bits.
// - A second word executed on its own behaves as a no-operation.
// - One cycle; two when a test is true or PC changes, extra is NOP.
// - Two-word instructions take two instruction cycles.
// - An instruction cycle is four oscillator periods from a divide-by-four.
// - Destination zero writes the accumulator, one writes the file register.
// - Byte operations decode file address, destination and access select.
// - Bit operations decode file address, bit number and access select.
// - Literal operations carry an immediate, a pointer selector, or nothing.
// - Control operations carry an address, call mode, table mode, or nothing.
// - Recognise the standard set plus eight extended instructions.
// - Sort words into byte, bit, literal and control classes.
// - Port read-modify-write by single-word byte operations uses pin levels; bit operations use the output latch.
// - Writing the timer zero count by a single-word byte operation clears an assigned prescaler.
`timescale 1ns/1ps
`include "mfd_regs.svh"

module mfd_decode import mfd_pkg::*; (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    input  wire logic [`MFD_WORD_W-1:0]    prog_word_i,
    input  wire logic                      cond_true_i,
    input  wire logic [3:0]                bank_sel_i,
    input  wire logic                      prescaler_assigned_i,
    input  wire logic                      extended_set_enable_i,
    input  wire logic [7:0]                port_pins_i,
    input  wire logic [7:0]                port_latch_i,
    output logic [`MFD_PHASE_W-1:0]        phase_o,
    output logic                           fetch_o,
    output mfd_class_e                     class_o,
    output logic                           exec_nop_o,
    output logic                           two_word_o,
    output logic [1:0]                     cycles_o,
    output logic [`MFD_FILE_W-1:0]         file_addr_o,
    output logic [`MFD_DADDR_W-1:0]        data_addr_o,
    output logic [`MFD_DADDR_W-1:0]        operand2_o,
    output logic                           to_working_accumulator_o,
    output logic [2:0]                     bit_num_o,
    output logic [11:0]                    literal_o,
    output logic [1:0]                     indirect_pointer_sel_o,
    output logic [`MFD_BRANCH_W-1:0]       branch_addr_o,
    output logic                           call_fast_o,
    output logic [1:0]                     table_mode_o,
    output logic                           ext_instr_o,
    output logic                           prescaler_clr_o,
    output logic [7:0]                     port_rmw_data_o
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // class by opcode bits
    function automatic mfd_class_e classify(input logic [15:0] w);
        mfd_class_e c;
        c = MFD_CLS_CTRL;
        unique case (w[15:12])
            4'h0: begin
                if (w[11:8] == 4'h0) c = MFD_CLS_CTRL;
                else if (w[11:8] == 4'h1 || w[11]) c = MFD_CLS_LIT;
                else c = MFD_CLS_BYTE;
            end
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc: c = MFD_CLS_BYTE;
            4'h7, 4'h8, 4'h9, 4'ha, 4'hb: c = MFD_CLS_BIT;
            4'he: c = (w[15:6] == `MFD_OP_PTRLOAD) ? MFD_CLS_LIT : MFD_CLS_CTRL;
            4'hd, 4'hf: c = MFD_CLS_CTRL;
        endcase
        return c;
    endfunction

    function automatic logic is_two_word(input logic [15:0] w);
        return (w[15:12] == `MFD_OP_MOVE2) || (w[15:9] == `MFD_OP_CALL)
            || (w[15:8] == `MFD_OP_GOTO) || (w[15:6] == `MFD_OP_PTRLOAD);
    endfunction

    function automatic logic is_word2(input logic [15:0] w);
        return w[15:12] == `MFD_WORD2_TAG;
    endfunction

    function automatic logic is_cond(input logic [15:0] w);
        return (w[15:11] == 5'b01100) || (w[15:10] == 6'b001011)
            || (w[15:10] == 6'b001111) || (w[15:11] == 5'b01001)
            || (w[15:13] == 3'b101) || (w[15:11] == 5'b11100);
    endfunction

    function automatic logic is_pc_change(input logic [15:0] w);
        return (w[15:12] == 4'hd) || (w[15:1] == 15'h0009);
    endfunction

    // Byte operations without a destination bit always write the file
    function automatic logic has_dest(input logic [15:0] w);
        return !((w[15:12] == 4'h6) || (w[15:9] == 7'h01) || (w[15:12] == `MFD_OP_MOVE2));
    endfunction

    function automatic logic [11:0] data_addr(input logic [15:0] w, input logic [3:0] bsr);
        if (w[`MFD_ACCESS_BIT]) return {bsr, w[7:0]};
        else if (w[7:0] < `MFD_ACCESS_SPLIT) return {`MFD_ACCESS_LO_BANK, w[7:0]};
        else return {`MFD_ACCESS_HI_BANK, w[7:0]};
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic       ext_meta_r;
    logic       ext_en_r;
    logic [7:0] pins_meta_r;
    logic [7:0] pins_r;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ext_meta_r  <= 1'b0;
            ext_en_r    <= 1'b0;
            pins_meta_r <= 8'h00;
            pins_r      <= 8'h00;
        end else begin
            ext_meta_r  <= extended_set_enable_i;
            ext_en_r    <= ext_meta_r;
            pins_meta_r <= port_pins_i;
            pins_r      <= pins_meta_r;
        end
    end

    // ****************************************************************
    // Cycle phases
    // ****************************************************************
    logic cycle_end;

    mfd_phase_div u_div (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .phase_o     (phase_o),
        .cycle_end_o (cycle_end)
    );

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fetch_o <= 1'b0;
        end else begin
            fetch_o <= cycle_end;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    mfd_seq_e        seq_r;
    logic [15:0]     word1_r;
    logic            cur_cond_r;
    logic            cur_pc_r;
    logic            flush_now;
    logic            start_two;
    logic            stray2;
    logic [15:0]     dec_word;
    logic            dec_valid;

    // taken test or PC change forces a NOP cycle
    assign flush_now = (seq_r == MFD_SEQ_RUN) && ((cur_cond_r && cond_true_i) || cur_pc_r);
    assign start_two = !flush_now && (seq_r != MFD_SEQ_WORD2) && is_two_word(prog_word_i);
    // lone second word runs as NOP
    assign stray2    = (seq_r != MFD_SEQ_WORD2) && is_word2(prog_word_i);
    assign dec_word  = (seq_r == MFD_SEQ_WORD2) ? word1_r : prog_word_i;
    assign dec_valid = !flush_now && !stray2;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            seq_r   <= MFD_SEQ_RUN;
            word1_r <= `MFD_NOP_WORD;
        end else if (cycle_end) begin
            unique case (seq_r)
                MFD_SEQ_RUN, MFD_SEQ_FLUSH: begin
                    if (flush_now) begin
                        seq_r <= MFD_SEQ_FLUSH;
                    end else if (start_two) begin
                        // hold first word for a second cycle
                        seq_r   <= MFD_SEQ_WORD2;
                        word1_r <= prog_word_i;
                    end else begin
                        seq_r <= MFD_SEQ_RUN;
                    end
                end
                MFD_SEQ_WORD2: seq_r <= MFD_SEQ_RUN;
            endcase
        end
    end

    // Flags of the instruction now executing
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur_cond_r <= 1'b0;
            cur_pc_r   <= 1'b0;
        end else if (cycle_end) begin
            cur_cond_r <= dec_valid && !start_two && is_cond(dec_word);
            cur_pc_r   <= dec_valid && !start_two && is_pc_change(dec_word);
        end
    end

    // ****************************************************************
    // Operand fields
    // ****************************************************************
    // fields split from the 16-bit word
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            class_o                <= MFD_CLS_CTRL;
            exec_nop_o             <= 1'b1;
            two_word_o             <= 1'b0;
            cycles_o               <= 2'h1;
            file_addr_o            <= '0;
            data_addr_o            <= '0;
            operand2_o             <= '0;
            to_working_accumulator_o <= 1'b0;
            bit_num_o              <= 3'h0;
            literal_o              <= 12'h000;
            indirect_pointer_sel_o <= 2'h0;
            branch_addr_o          <= '0;
            call_fast_o            <= 1'b0;
            table_mode_o           <= 2'h0;
            ext_instr_o            <= 1'b0;
        end else if (cycle_end) begin
            class_o    <= dec_valid ? classify(dec_word) : MFD_CLS_CTRL;
            exec_nop_o <= !dec_valid || start_two;
            two_word_o <= (seq_r == MFD_SEQ_WORD2);
            // two-word and PC-changing take two cycles
            cycles_o   <= ((seq_r == MFD_SEQ_WORD2) || (dec_valid && is_pc_change(dec_word))) ? 2'h2 : 2'h1;
            file_addr_o <= dec_word[`MFD_FILE_LSB +: `MFD_FILE_W];
            data_addr_o <= (dec_word[15:12] == `MFD_OP_MOVE2) ? dec_word[11:0] : data_addr(dec_word, bank_sel_i);
            operand2_o  <= prog_word_i[11:0];
            to_working_accumulator_o <= dec_valid && (classify(dec_word) == MFD_CLS_BYTE)
                                        && has_dest(dec_word) && !dec_word[`MFD_DEST_BIT];
            bit_num_o <= dec_word[`MFD_BITNUM_LSB +: 3];
            literal_o <= (dec_word[15:6] == `MFD_OP_PTRLOAD) ? {dec_word[3:0], prog_word_i[7:0]}
                                                             : {4'h0, dec_word[7:0]};
            indirect_pointer_sel_o <= dec_word[5:4];
            // branch address, call and table modes
            if (seq_r == MFD_SEQ_WORD2) begin
                branch_addr_o <= {prog_word_i[11:0], dec_word[7:0]};
            end else if (dec_word[15:12] == 4'hd) begin
                branch_addr_o <= {{9{dec_word[10]}}, dec_word[10:0]};
            end else begin
                branch_addr_o <= {{12{dec_word[7]}}, dec_word[7:0]};
            end
            call_fast_o  <= (dec_word[15:9] == `MFD_OP_CALL) ? dec_word[8] : dec_word[0];
            table_mode_o <= dec_word[1:0];
            ext_instr_o  <= dec_valid && ext_en_r && (dec_word[15:10] == 6'b111010);
        end
    end

    // ****************************************************************
    // Side effects on ports and timer
    // ****************************************************************
    logic [11:0] side_addr;
    logic        side_writes;

    assign side_addr   = data_addr(prog_word_i, bank_sel_i);
    assign side_writes = dec_valid && !start_two && (seq_r != MFD_SEQ_WORD2)
                         && (classify(prog_word_i) == MFD_CLS_BYTE) && (prog_word_i[15:12] != `MFD_OP_MOVE2)
                         && (!has_dest(prog_word_i) || prog_word_i[`MFD_DEST_BIT]);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prescaler_clr_o <= 1'b0;
        end else begin
            prescaler_clr_o <= cycle_end && side_writes && prescaler_assigned_i
                               && (side_addr == `MFD_TIMER0_ADDR);
        end
    end

    logic port_rmw_r;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            port_rmw_r <= 1'b0;
        end else if (cycle_end) begin
            port_rmw_r <= side_writes && (side_addr >= `MFD_PORT_ADDR_LO) && (side_addr <= `MFD_PORT_ADDR_HI);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            port_rmw_data_o <= 8'h00;
        end else begin
            port_rmw_data_o <= port_rmw_r ? pins_r : port_latch_i;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    phase_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        fetch_o |-> ##4 fetch_o)
        else $error("fetch not every four clocks");

    flush_nop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cycle_end && flush_now) |=> exec_nop_o)
        else $error("extra cycle not a nop");

    stray_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cycle_end && stray2) |=> exec_nop_o && class_o == MFD_CLS_CTRL)
        else $error("lone second word executed");

    two_cycle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cycle_end && start_two) |=> exec_nop_o ##4 (two_word_o && cycles_o == 2'h2))
        else $error("two-word not two cycles");

    word2_tag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cycle_end && seq_r != MFD_SEQ_WORD2 && prog_word_i[15:12] == 4'hf) |=> exec_nop_o)
        else $error("tagged second word not a nop");

    dest_acc_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        to_working_accumulator_o |-> class_o == MFD_CLS_BYTE && !exec_nop_o)
        else $error("accumulator target outside byte op");

    access_bank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cycle_end && dec_valid && dec_word[8] && dec_word[15:12] != `MFD_OP_MOVE2)
        |=> data_addr_o[11:8] == $past(bank_sel_i))
        else $error("bank select not applied");

    prescale_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        prescaler_clr_o |-> $past(prescaler_assigned_i) && fetch_o)
        else $error("prescaler cleared without cause");

endmodule

// >>> tb/mfd_prog_mem.sv
// Program memory model that feeds 16-bit words to the decoder.
// Assumes fetch_i pulses once per instruction cycle, after each decode edge.
`timescale 1ns/1ps
`include "mfd_regs.svh"

module mfd_prog_mem (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   fetch_i,
    output logic [`MFD_WORD_W-1:0]      word_o,
    output logic [7:0]                  idx_o
);
    logic [`MFD_WORD_W-1:0] rom_r [0:63];

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Unused places hold a lone second word, which decodes as a NOP
    initial begin
        for (int i = 0; i < 64; i++) begin
            rom_r[i] = `MFD_NOP_WORD;
        end
    end

    task automatic load(input int a, input logic [`MFD_WORD_W-1:0] w);
        rom_r[a] = w;
    endtask

    // ****************************************************************
    // Sequential fetch
    // ****************************************************************
    // Jumps are not modelled: the word stream stays linear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            idx_o <= 8'h00;
        end else if (fetch_i) begin
            idx_o <= idx_o + 8'h01;
        end
    end

    assign word_o = rom_r[idx_o[5:0]];
endmodule

// >>> tb/mfd_decode_tb.sv
// Self-checking bench for the instruction format decoder.
// Assumes the program memory model and the decoder share one 10 MHz clock.
`timescale 1ns/1ps
`include "mfd_regs.svh"

module mfd_decode_tb import mfd_pkg::*;;
    typedef struct {int kind; mfd_class_e cls; logic [7:0] fa; logic [11:0] da;
                    logic tow; logic [11:0] op2; logic pclr; logic port; logic [15:0] w;} mfd_exp_s;
    logic mclk_i, rst_n_i, cond_true_i, presc_i, fetch_o, exec_nop_o, two_word_o, tow_o, pclr_o;
    logic xen, cfast_o, ext_o;
    logic [2:0]  bitn_o;
    logic [19:0] ba_o;
    logic [15:0] word;
    logic [7:0]  idx, pins, file_addr_o, rmw_o;
    logic [3:0]  bank;
    logic [1:0]  phase_o, cycles_o, psel_o, tmode_o;
    logic [11:0] data_addr_o, operand2_o, lit_o;
    mfd_class_e  class_o;
    mfd_exp_s    exp_q[$];
    logic        cond_arr [0:63];
    logic        presc_arr [0:63];
    int miscompares = 0, checks_done = 0, n = 0, cyc = 0, last_fetch = 0;
    logic [7:0] lf = 8'h42;
    logic port_pend = 1'b0;
    logic [7:0] pins_exp;

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    mfd_prog_mem mfd_prog_mem_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fetch_i(fetch_o), .word_o(word), .idx_o(idx));

    mfd_decode mfd_decode_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .prog_word_i(word), .cond_true_i(cond_true_i),
        .bank_sel_i(bank), .prescaler_assigned_i(presc_i), .extended_set_enable_i(xen), .port_pins_i(pins),
        .port_latch_i(~pins), .phase_o(phase_o), .fetch_o(fetch_o), .class_o(class_o), .exec_nop_o(exec_nop_o),
        .two_word_o(two_word_o), .cycles_o(cycles_o), .file_addr_o(file_addr_o), .data_addr_o(data_addr_o),
        .operand2_o(operand2_o), .to_working_accumulator_o(tow_o), .bit_num_o(bitn_o), .literal_o(lit_o),
        .indirect_pointer_sel_o(psel_o), .branch_addr_o(ba_o), .call_fast_o(cfast_o), .table_mode_o(tmode_o),
        .ext_instr_o(ext_o),
        .prescaler_clr_o(pclr_o), .port_rmw_data_o(rmw_o));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [19:0] seen, input logic [19:0] expv);
        checks_done++;
        if (seen !== expv) begin
            miscompares++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, expv);
        end
    endtask

    task automatic put(input logic [15:0] w, input int kind, input logic [11:0] da, input logic tow,
                       input logic cnext, input logic pr, input logic pc, input logic port);
        mfd_exp_s e;
        e = '{kind, (kind == 0) ? MFD_CLS_BYTE : ((kind == 6) ? MFD_CLS_BIT : MFD_CLS_CTRL),
              w[7:0], da, tow, w[11:0], pc, port, w};
        mfd_prog_mem_i.load(n, w);
        presc_arr[n] = pr;
        cond_arr[n + 1] = cnext;
        exp_q.push_back(e);
        n++;
    endtask

    // Byte op: access bank when a is 0, bank select otherwise
    task automatic put_byte(input logic [5:0] top, input logic d, input logic a, input logic [7:0] f,
                            input logic hasd, input logic cnext, input logic pr);
        logic [11:0] da;
        logic [3:0]  hb;
        hb = f[7] ? `MFD_ACCESS_HI_BANK : `MFD_ACCESS_LO_BANK;
        da = a ? {bank, f} : {hb, f};
        put({top, d, a, f}, 0, da, hasd & ~d, cnext, pr, pr & d & (da == `MFD_TIMER0_ADDR),
            d & (da >= `MFD_PORT_ADDR_LO) & (da <= `MFD_PORT_ADDR_HI));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Output watcher
    // ****************************************************************
    always @(posedge mclk_i) begin : watch
        mfd_exp_s e;
        #1;
        cyc++;
        if (port_pend) begin
            check(rmw_o, pins_exp);
            port_pend = 1'b0;
        end
        if (rst_n_i === 1'b1 && fetch_o === 1'b1) begin
            check(phase_o, 2'h0);
            if (last_fetch > 0) check(cyc - last_fetch, 4);
            last_fetch = cyc;
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check(exec_nop_o, e.kind == 1 || e.kind == 3);
                if (e.kind == 0 || e.kind == 6) begin
                    check(class_o, e.cls);
                    check({file_addr_o, data_addr_o}, {e.fa, e.da});
                    check(tow_o, e.tow);
                    check({two_word_o, cycles_o}, 3'h1);
                    check(pclr_o, e.pclr);
                    check(ext_o, 1'b0);
                    if (e.kind == 6) check(bitn_o, e.w[11:9]);
                    port_pend = e.port;
                end else if (e.kind == 2 || e.kind == 7) begin
                    check({two_word_o, cycles_o}, 3'h6);
                    check(operand2_o, e.op2);
                    // Pointer load: pointer two, literal noted in da
                    if (e.kind == 2) check(data_addr_o, e.da);
                    else check({psel_o, lit_o}, {2'h2, e.da});
                end else if (e.kind == 3) begin
                    check(class_o, MFD_CLS_CTRL);
                end else if (e.kind >= 4) begin
                    check(class_o, MFD_CLS_CTRL);
                    check({two_word_o, cycles_o}, (e.kind == 4) ? 3'h2 : 3'h1);
                    check(ext_o, e.w[15:10] == 6'b111010);
                    if (e.kind == 4) check(ba_o, {{9{e.w[10]}}, e.w[10:0]});
                    else if (e.w[15:8] == 8'h00) check({cfast_o, tmode_o}, {e.w[0], e.w[1:0]});
                end
            end
        end
    end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    always @(posedge mclk_i) begin
        #5;
        cond_true_i <= cond_arr[idx[5:0]];
        presc_i     <= presc_arr[idx[5:0]];
    end

    initial begin : main
        logic [5:0] ops [0:6];
        int k;
        ops = '{6'b001001, 6'b000101, 6'b000111, 6'b000100, 6'b010100, 6'b001101, 6'b000110};
        rst_n_i = 1'b0;
        xen = 1'b1;
        for (int i = 0; i < 64; i++) begin
            cond_arr[i] = 1'b0;
            presc_arr[i] = 1'b0;
        end
        lf = lfsr(lf);
        pins = lf;
        pins_exp = lf;
        lf = lfsr(lf);
        bank = lf[3:0] & 4'h7;
        #1;
        for (int i = 0; i < 14; i++) begin
            lf = lfsr(lf);
            k = lf % 7;
            put_byte(ops[k], lf[7], lf[6], lfsr(lf) & (lf[6] ? 8'hff : 8'h7f), 1'b1, 1'b0, 1'b0);
        end
        put(16'hc3a5, 1, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'hf15c, 2, 12'h3a5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'hf5a5, 3, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        // skip taken flushes the next word
        put_byte(6'b011001, 1'b1, 1'b0, 8'h12, 1'b0, 1'b1, 1'b0);
        put(16'h2412, 1, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put_byte(6'b010100, 1'b1, 1'b0, 8'hd6, 1'b1, 1'b0, 1'b1);
        put_byte(6'b010100, 1'b1, 1'b0, 8'hd6, 1'b1, 1'b0, 1'b0);
        put_byte(6'b010100, 1'b0, 1'b0, 8'hd6, 1'b1, 1'b0, 1'b1);
        put_byte(6'b010100, 1'b1, 1'b0, 8'h81, 1'b1, 1'b0, 1'b0);
        put_byte(6'b001001, 1'b0, 1'b1, 8'h40, 1'b1, 1'b0, 1'b0);
        // bit set through the bank select
        put(16'h8b47, 6, {bank, 8'h47}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        // branch flushes the word after it
        put(16'hd405, 4, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'h2412, 1, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'h000a, 5, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'he8a1, 5, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'hee25, 1, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        put(16'hf0c3, 7, 12'h5c3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (8) @(posedge mclk_i);
        #5;
        rst_n_i = 1'b1;
        k = 0;
        while (k < 400 && (exp_q.size() > 0 || port_pend)) begin
            @(posedge mclk_i);
            k++;
        end
        if (k >= 400) miscompares++;
        repeat (2) @(posedge mclk_i);
        tally_and_finish();
    end
endmodule
